// ### src/sldrv_pkg.sv
`include "sldrv_regs.svh"
package sldrv_pkg;
	typedef logic [`SLDRV_CHANNELS-1:0] sldrv_word_t;
endpackage

// ### src/sldrv_regs.svh
`ifndef SLDRV_REGS_SVH
`define SLDRV_REGS_SVH

// Number of driver channels
`define SLDRV_CHANNELS 32
// Reset value of stages, latches and outputs
`define SLDRV_RESET_BITS 32'h0000_0000
// Buffer depth in entries
`define SLDRV_BUF_DEPTH 2
`endif

// ### src/sldrv_top.sv
`include "sldrv_regs.svh"
module sldrv_top (
	input  wire logic             clk_sys,       // System clock, 200 MHz
	input  wire logic             rstn,          // Synchronous reset, low
	input  wire logic             serialClk,     // Link clock, sampled
	input  wire logic             serialIn,      // Serial data in
	input  wire logic             latchLoad,     // Latch load, high = copy
	input  wire logic             blanking,      // Blanking, high = all low
	input  wire logic             outReady,      // Output sink ready
	output logic                  outValid,      // Output word valid
	output sldrv_pkg::sldrv_word_t driverOutput, // Parallel outputs
	output logic                  serialOut,     // Cascade serial out
	output logic                  inReady        // Buffer can take a word
);
	// Pipeline, one clock per step: a sampled rise of the link clock
	// shifts the chain, the latches copy the chain on the next clock,
	// the blanked latch word enters the buffer on the clock after that,
	// and reaches the parallel outputs on that same clock if the buffer was empty.
	// A stalled sink holds at most two distinct words; a later change
	// waits for room and only the newest waiting word is delivered, so
	// short-lived states between two settled words may be skipped.
	// The link clock is sampled, so it must stay well below clk_sys:
	// each of its levels has to last at least one clk_sys cycle.

	// Sizes for loops and buffer bookkeeping
	localparam int         Chans = `SLDRV_CHANNELS;
	localparam logic [1:0] Full  = 2'(`SLDRV_BUF_DEPTH);

	// Link clock sampling
	logic                   clkPrev;
	logic                   next_clkPrev;
	logic                   rise;

	// Shift chain
	sldrv_pkg::sldrv_word_t stages;
	sldrv_pkg::sldrv_word_t next_stages;
	sldrv_pkg::sldrv_word_t stageIn;

	// Latches
	sldrv_pkg::sldrv_word_t latches;
	sldrv_pkg::sldrv_word_t next_latches;

	// Blanked word that feeds the buffer
	sldrv_pkg::sldrv_word_t outWord;

	// Two entry buffer
	sldrv_pkg::sldrv_word_t bufData [`SLDRV_BUF_DEPTH];
	sldrv_pkg::sldrv_word_t next_bufData [`SLDRV_BUF_DEPTH];
	logic [1:0]             bufCount;
	logic [1:0]             next_bufCount;
	sldrv_pkg::sldrv_word_t lastPushed;
	sldrv_pkg::sldrv_word_t next_lastPushed;
	logic                   push;
	logic                   pop;
	logic                   pushSlot;
	logic                   next_outValid;
	sldrv_pkg::sldrv_word_t next_driverOutput;
	logic                   next_inReady;

	// Cascade output
	logic                   next_serialOut;

	// Next value of the sampled link clock
	always_comb begin
		next_clkPrev = serialClk;
	end

	// A rise is a high sample after a low one; the previous sample
	// resets to the idle low level, so no false rise follows reset
	assign rise = serialClk & ~clkPrev;

	// Previous link clock sample
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			clkPrev <= 1'h0;
		end else begin
			clkPrev <= next_clkPrev;
		end
	end

	// What each stage takes on a rise: stage zero the serial input,
	// every other stage its neighbour nearer the input
	for (genvar gi = 0; gi < Chans; gi++) begin : g_stage
		if (gi == 0) begin : g_first
			assign stageIn[gi] = serialIn;
		end else begin : g_rest
			assign stageIn[gi] = stages[gi-1];
		end
	end

	// Shift only on a detected rise, otherwise hold
	always_comb begin
		next_stages = stages;
		if (rise) begin
			next_stages = stageIn;
		end
	end

	// Shift chain registers
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			stages <= `SLDRV_RESET_BITS;
		end else begin
			stages <= next_stages;
		end
	end

	// Latches copy the chain while load is high and hold otherwise;
	// the copy is registered, so a latch trails its stage by a cycle,
	// which trades one cycle of delay for a loop-free latch path
	always_comb begin
		next_latches = latches;
		if (latchLoad) begin
			next_latches = stages;
		end
	end

	// Latch registers; blanking is kept away from them on purpose
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			latches <= `SLDRV_RESET_BITS;
		end else begin
			latches <= next_latches;
		end
	end

	// Blanking forces the word low without touching the latches
	always_comb begin
		outWord = blanking ? '0 : latches;
	end

	// Two entry buffer: a word is pushed when the blanked word changes,
	// so a stalled sink sees only changed states, not a copy per cycle.
	// A push is refused while full; the changed word stays pending
	// because the last pushed word is not updated.
	// When the last word drains, the head keeps it, so the parallel
	// outputs never fall back to stale buffer contents.
	always_comb begin
		push              = (outWord != lastPushed) && (bufCount != Full);
		pop               = outValid && outReady;
		pushSlot          = pop ? 1'h0 : bufCount[0];
		next_bufData      = bufData;
		if (pop && (bufCount == Full)) begin
			next_bufData[0] = bufData[1];
		end
		if (push) begin
			next_bufData[pushSlot] = outWord;
		end
		next_bufCount     = bufCount + {1'h0, push} - {1'h0, pop};
		next_lastPushed   = push ? outWord : lastPushed;
		next_outValid     = next_bufCount != 2'h0;
		next_driverOutput = next_bufData[0];
		next_inReady      = next_bufCount != Full;
	end

	// Buffer registers; the head drives the ports straight from flops
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			bufData[0]   <= `SLDRV_RESET_BITS;
			bufData[1]   <= `SLDRV_RESET_BITS;
			bufCount     <= 2'h0;
			lastPushed   <= `SLDRV_RESET_BITS;
			outValid     <= 1'h0;
			driverOutput <= `SLDRV_RESET_BITS;
			inReady      <= 1'h0;
		end else begin
			bufData      <= next_bufData;
			bufCount     <= next_bufCount;
			lastPushed   <= next_lastPushed;
			outValid     <= next_outValid;
			driverOutput <= next_driverOutput;
			inReady      <= next_inReady;
		end
	end

	// The cascade bit leaves with the shift that moves it into place,
	// so a downstream chain sees it on the next link clock rise
	always_comb begin
		next_serialOut = next_stages[Chans-1];
	end

	// Cascade output register
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			serialOut <= 1'h0;
		end else begin
			serialOut <= next_serialOut;
		end
	end
endmodule

// ### verification/serial_latched_output_driver_tb.sv
module serial_latched_output_driver_tb;
	timeunit 1ns; timeprecision 1ps;
	`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
		mismatches++; $display("CHECK FAILED %0t bad value", $time); end end
	logic clk_sys = 0, rstn = 0, latchLoad = 0, blanking = 0, outReady = 1;
	logic serialClk, serialIn, outValid, serialOut, inReady;
	sldrv_pkg::sldrv_word_t driverOutput;
	int mismatches = 0, checks_done = 0;
	sldrv_ctrl ctl (.clk_sys, .serialClk, .serialIn);
	sldrv_top uut (.clk_sys, .rstn, .serialClk, .serialIn, .latchLoad,
		.blanking, .outReady, .outValid, .driverOutput, .serialOut, .inReady);
	initial forever #2.5 clk_sys = ~clk_sys;
	task automatic cyc(input int n); repeat (n) @(posedge clk_sys); #1; endtask
	task automatic close_out;
		if (mismatches == 0 && checks_done > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// Serial entry with the latches closed: only the cascade bit moves
	task automatic scen_shift;
		ctl.send(32'ha5c3_0f96);
		cyc(4);
		`CHK(serialOut, 1'h1)
		`CHK(outValid, 1'h0)
		`CHK(driverOutput, 32'h0)
		`CHK(inReady, 1'h1)
	endtask
	// Load the latches, then blank and unblank the outputs
	task automatic scen_latch_blank;
		latchLoad = 1;
		cyc(2);
		latchLoad = 0;
		cyc(4);
		`CHK(driverOutput, 32'ha5c3_0f96)
		`CHK(outValid, 1'h0)
		blanking = 1;
		cyc(6);
		`CHK(driverOutput, 32'h0)
		blanking = 0;
		cyc(6);
		`CHK(driverOutput, 32'ha5c3_0f96)
	endtask
	// Transparent latches kept blanked while a new word shifts in
	task automatic scen_transparent;
		blanking = 1;
		latchLoad = 1;
		ctl.send(32'h3c5a_9617);
		cyc(4);
		`CHK(driverOutput, 32'h0)
		blanking = 0;
		cyc(6);
		`CHK(driverOutput, 32'h3c5a_9617)
		`CHK(serialOut, 1'h0)
		latchLoad = 0;
		cyc(2);
	endtask
	// Stalled sink: two words wait, a third change waits for room
	task automatic scen_stall;
		outReady = 0;
		blanking = 1;
		cyc(2);
		blanking = 0;
		cyc(2);
		blanking = 1;
		cyc(2);
		`CHK(outValid, 1'h1)
		`CHK(inReady, 1'h0)
		`CHK(driverOutput, 32'h0)
		outReady = 1;
		cyc(1);
		`CHK(driverOutput, 32'h3c5a_9617)
		`CHK(inReady, 1'h1)
		cyc(1);
		`CHK(driverOutput, 32'h0)
		cyc(2);
		`CHK(outValid, 1'h0)
		blanking = 0;
		cyc(4);
		`CHK(driverOutput, 32'h3c5a_9617)
	endtask
	// Reset is held long enough for every stage to clear
	initial begin
		cyc(10);
		rstn = 1;
		scen_shift;
		scen_latch_blank;
		scen_transparent;
		scen_stall;
		close_out;
	end
endmodule

// ### verification/sldrv_ctrl.sv
module sldrv_ctrl (
	input wire logic clk_sys,          // Clock
	output logic     serialClk = 1'h0, // Link clock, still when idle
	output logic     serialIn = 1'h0   // Data, MSB first
);
	timeunit 1ns; timeprecision 1ps;
	// Data is set a cycle ahead so the sampled edge never races it
	task automatic send(input sldrv_pkg::sldrv_word_t w);
		for (int i = 31; i >= 0; i--) begin
			@(posedge clk_sys) #1 serialIn = w[i];
			@(posedge clk_sys) #1 serialClk = 1'h1;
			@(posedge clk_sys) #1 serialClk = 1'h0;
		end
		serialIn = ~serialIn; // No stale bit on the idle line
	endtask
endmodule

// ### verification/sldrv_top_props.sv
module sldrv_chk (
	input wire logic                   clk_sys,      // Clock
	input wire logic                   rstn,         // Reset, low
	input wire logic                   serialClk,    // Link clock
	input wire logic                   latchLoad,    // Latch load
	input wire logic                   blanking,     // Blanking
	input wire logic                   outReady,     // Sink ready
	input wire logic                   outValid,     // Word valid
	input wire sldrv_pkg::sldrv_word_t driverOutput, // Parallel outputs
	input wire logic                   serialOut,    // Cascade bit
	input wire logic                   inReady       // Buffer has room
);
	timeunit 1ns; timeprecision 1ps;
	// Cascade bit moves only on a sampled rise of the link clock
	property p_shift;
		@(posedge clk_sys) disable iff (!rstn)
		$changed(serialOut) |-> $past(serialClk) && !$past(serialClk, 2);
	endproperty
	a_shift: assert property (p_shift)
		else $error("Stray shift");
	// Three blanked cycles with a ready sink leave the outputs low
	property p_blank;
		@(posedge clk_sys) disable iff (!rstn)
		(blanking && outReady)[*3] |-> driverOutput == '0;
	endproperty
	a_blank: assert property (p_blank)
		else $error("Outputs not blanked");
	// Closed latches keep the outputs still while the chain shifts
	property p_hold;
		@(posedge clk_sys) disable iff (!rstn)
		(!latchLoad && !blanking && outReady)[*4] |-> $stable(driverOutput);
	endproperty
	a_hold: assert property (p_hold)
		else $error("Outputs moved with latches closed");
	// An empty buffer leaves the outputs on the last delivered word
	property p_idle;
		@(posedge clk_sys) disable iff (!rstn)
		!outValid && !$past(outValid) |-> $stable(driverOutput);
	endproperty
	a_idle: assert property (p_idle)
		else $error("Outputs moved while empty");
	// An empty buffer has room, except in the first cycle after reset
	property p_room;
		@(posedge clk_sys) disable iff (!rstn)
		$past(rstn) && !outValid |-> inReady;
	endproperty
	a_room: assert property (p_room)
		else $error("Empty buffer without room");
	// A taken word frees a slot by the next cycle
	property p_drain;
		@(posedge clk_sys) disable iff (!rstn)
		outValid && outReady |=> inReady;
	endproperty
	a_drain: assert property (p_drain)
		else $error("No room after a pop");
	// Outputs start low after reset
	property p_reset;
		@(posedge clk_sys) disable iff (!rstn)
		!$past(rstn) |-> !outValid && !serialOut && driverOutput == '0;
	endproperty
	a_reset: assert property (p_reset)
		else $error("Outputs not clear after reset");
endmodule
bind sldrv_top sldrv_chk chk (.clk_sys, .rstn, .serialClk, .latchLoad,
	.blanking, .outReady, .outValid, .driverOutput, .serialOut, .inReady);
